/* mcu_partner_model.sv */
// behavioural system controller sending enable commands
`timescale 1ns/1ps
module mcu_partner_model (
	input wire logic core_clk,
	input wire logic driverEnableIrqN,
	input wire logic [2:0] req,
	output logic lockClr = 1'b0,
	output logic lvSet = 1'b0,
	output logic suSet = 1'b0,
	output logic suClr = 1'b0
);
	// restarts go out only while the interrupt is pending, else dropped
	always @(posedge core_clk) begin
		lockClr <= (req[0] | req[1]) & !driverEnableIrqN;
		lvSet <= req[0] & !driverEnableIrqN;
		suSet <= req[1] & !driverEnableIrqN;
		suClr <= req[2];
	end
endmodule

/* persistence_timer.sv */
// counts how long a condition has held and flags when a limit is reached
`timescale 1ns/1ps
module persistence_timer #(
	parameter int LIMIT = 1
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clkEnable,
	input wire logic run,
	output logic done
);
	localparam int W = $clog2(LIMIT + 1);
	localparam logic [W-1:0] LIM = W'(LIMIT);

	logic [W-1:0] count;
	logic [W-1:0] next_count;
	logic next_done;

	// dropping run restarts the interval from zero
	always_comb begin
		next_count = '0;
		next_done = 1'b0;
		if (run) begin
			next_count = (count == LIM) ? count : count + 1'b1;
			next_done = (next_count == LIM);
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			count <= '0;
			done <= 1'b0;
		end else if (clkEnable) begin
			count <= next_count;
			done <= next_done;
		end
	end
endmodule

/* regulator_fault_pkg.sv */
// constants, flag layout and state encoding of the regulator fault response
//----------------------------------------------------------------
// How it works
//----------------------------------------------------------------
// How it works
// - buck warning sets flag; pin goes low only when its irq enable is one
// - buck thermal shutdown: SAFE, buck off, enable cleared, flag, count, pin low
// - after buck shutdown, buck undervoltage with reset enable one enters RESET
// - after thermal shutdown buck stays off until cooled, even with enable bit set
// - buck overvoltage: SAFE, buck off, enable cleared, flag, count, pin low
// - buck overvoltage still present for off delay while off: OFF, latch flag
// - step-up enable is one at power-up; MCU may clear it later
// - soft-start runs 2 ms after input ramp; shutdown, wake low or OFF restart it
// - step-up undervoltage, overvoltage and protection events set separate flags
// - step-up overload sets overload flag; converter keeps running
// - step-up short: off once current drops, flag, enable cleared, SAFE, count, pin
// - after step-up shutdown, undervoltage with reset enable one enters RESET
// - sink current sets flag; lasting over 20 us acts like a short circuit
// - sink event masked from enable until output first passes undervoltage level
// - re-enable during current limit switches converter off again and counts
// - step-up warning sets flag; pin goes low if pin high and irq enable one
// - step-up thermal shutdown: SAFE, off, enable cleared, flag, count, pin low
// - after thermal shutdown step-up stays off until cooled below hysteresis
// - step-up overvoltage: SAFE, off, enable cleared, flag, count, pin low
// - step-up overvoltage still present for off delay while off: OFF, latch flag
package regulator_fault_pkg;
	//----------------------------------------------------------------
	// timing
	//----------------------------------------------------------------
	localparam int CLK_MHZ = 100;
	localparam int SINK_TIME_US = 20;
	localparam int SINK_CYCLES = SINK_TIME_US * CLK_MHZ;
	localparam int SOFT_START_MS = 2;
	localparam int SOFT_START_CYCLES = SOFT_START_MS * 1000 * CLK_MHZ;
	localparam int OVP_OFF_DELAY_US = 10;
	localparam int OVP_OFF_CYCLES = OVP_OFF_DELAY_US * CLK_MHZ;
	localparam int ERR_CNT_WIDTH = 4;

	//----------------------------------------------------------------
	// synchronised comparator inputs
	//----------------------------------------------------------------
	localparam int NUM_IN = 16;
	localparam int IN_LV_WARN = 0;
	localparam int IN_LV_STD = 1;
	localparam int IN_LV_COOL = 2;
	localparam int IN_LV_OVP = 3;
	localparam int IN_LV_UV = 4;
	localparam int IN_SU_UV = 5;
	localparam int IN_SU_OV = 6;
	localparam int IN_SU_OVP = 7;
	localparam int IN_SU_OVERLOAD = 8;
	localparam int IN_SU_SHORT = 9;
	localparam int IN_SU_SINK = 10;
	localparam int IN_SU_WARN = 11;
	localparam int IN_SU_STD = 12;
	localparam int IN_SU_COOL = 13;
	localparam int IN_RAMP_DONE = 14;
	localparam int IN_WAKE = 15;

	//----------------------------------------------------------------
	// status flags
	//----------------------------------------------------------------
	localparam int NUM_FLAGS = 11;
	localparam int FL_LV_WARN = 0;
	localparam int FL_LV_STD = 1;
	localparam int FL_LV_OVP = 2;
	localparam int FL_SU_UV = 3;
	localparam int FL_SU_OV = 4;
	localparam int FL_SU_OVP = 5;
	localparam int FL_SU_OVERLOAD = 6;
	localparam int FL_SU_SHORT = 7;
	localparam int FL_SU_SINK = 8;
	localparam int FL_SU_WARN = 9;
	localparam int FL_SU_STD = 10;
	localparam logic [NUM_FLAGS-1:0] FAULT_IRQ_MASK = 11'h4A6;
	localparam logic [NUM_FLAGS-1:0] FLAGS_RESET = 11'h000;

	localparam logic ENABLE_RESET = 1'h1;

	typedef enum logic [3:0] {
		ST_ACTIVE = 4'h1,
		ST_SAFE = 4'h2,
		ST_RESET = 4'h4,
		ST_OFF = 4'h8
	} devState_t;
endpackage

/* regulator_fault_response.sv */
// fault reaction for the low-voltage buck and the step-up converter
`timescale 1ns/1ps
module regulator_fault_response #(
	parameter int SOFT_START_CYCLES = regulator_fault_pkg::SOFT_START_CYCLES,
	parameter int SINK_CYCLES = regulator_fault_pkg::SINK_CYCLES,
	parameter int LV_OVP_OFF_CYCLES = regulator_fault_pkg::OVP_OFF_CYCLES,
	parameter int SU_OVP_OFF_CYCLES = regulator_fault_pkg::OVP_OFF_CYCLES,
	parameter int ERR_CNT_WIDTH = regulator_fault_pkg::ERR_CNT_WIDTH
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clkEnable,
	input wire logic lvBuckOtWarn,
	input wire logic lvBuckOtShutdown,
	input wire logic lvBuckCooled,
	input wire logic lvBuckOvp,
	input wire logic lvBuckUv,
	input wire logic stepUpUv,
	input wire logic stepUpOv,
	input wire logic stepUpOvp,
	input wire logic stepUpOverload,
	input wire logic stepUpShortCircuit,
	input wire logic stepUpSink,
	input wire logic stepUpOtWarn,
	input wire logic stepUpOtShutdown,
	input wire logic stepUpCooled,
	input wire logic wideBuckRampDone,
	input wire logic wakePin,
	input wire logic swLvBuckEnableSet,
	input wire logic swLvBuckEnableClear,
	input wire logic swStepUpEnableSet,
	input wire logic swStepUpEnableClear,
	input wire logic swControlLockClear,
	input wire logic [regulator_fault_pkg::NUM_FLAGS-1:0] swFlagClear,
	input wire logic lvBuckOvertempWarningIrqEnable,
	input wire logic stepUpOvertempWarningIrqEnable,
	input wire logic lvBuckUndervoltageResetEnable,
	input wire logic stepUpUndervoltageResetEnable,
	output logic driverEnableIrqN,
	output logic lvBuckEnableBit,
	output logic lvBuckOn,
	output logic stepUpEnableBit,
	output logic stepUpOn,
	output logic stepUpSoftStartDone,
	output logic controlLock,
	output logic [3:0] deviceState,
	output logic [ERR_CNT_WIDTH-1:0] deviceErrorCounter,
	output logic [regulator_fault_pkg::NUM_FLAGS-1:0] statusFlags,
	output logic lvBuckOvpLatched,
	output logic stepUpOvpLatched
);
	localparam int NI = regulator_fault_pkg::NUM_IN;

	//----------------------------------------------------------------
	// input synchronisers
	//----------------------------------------------------------------
	logic [NI-1:0] rawIn;
	logic [NI-1:0] syncA;
	logic [NI-1:0] syncB;
	logic [NI-1:0] syncC;
	logic [NI-1:0] filt;
	logic [NI-1:0] filtPrev;
	logic [NI-1:0] next_filt;
	logic [NI-1:0] rise;

	assign rawIn[regulator_fault_pkg::IN_LV_WARN] = lvBuckOtWarn;
	assign rawIn[regulator_fault_pkg::IN_LV_STD] = lvBuckOtShutdown;
	assign rawIn[regulator_fault_pkg::IN_LV_COOL] = lvBuckCooled;
	assign rawIn[regulator_fault_pkg::IN_LV_OVP] = lvBuckOvp;
	assign rawIn[regulator_fault_pkg::IN_LV_UV] = lvBuckUv;
	assign rawIn[regulator_fault_pkg::IN_SU_UV] = stepUpUv;
	assign rawIn[regulator_fault_pkg::IN_SU_OV] = stepUpOv;
	assign rawIn[regulator_fault_pkg::IN_SU_OVP] = stepUpOvp;
	assign rawIn[regulator_fault_pkg::IN_SU_OVERLOAD] = stepUpOverload;
	assign rawIn[regulator_fault_pkg::IN_SU_SHORT] = stepUpShortCircuit;
	assign rawIn[regulator_fault_pkg::IN_SU_SINK] = stepUpSink;
	assign rawIn[regulator_fault_pkg::IN_SU_WARN] = stepUpOtWarn;
	assign rawIn[regulator_fault_pkg::IN_SU_STD] = stepUpOtShutdown;
	assign rawIn[regulator_fault_pkg::IN_SU_COOL] = stepUpCooled;
	assign rawIn[regulator_fault_pkg::IN_RAMP_DONE] = wideBuckRampDone;
	assign rawIn[regulator_fault_pkg::IN_WAKE] = wakePin;

	// a bit only moves once the second and third stage agree
	always_comb begin
		for (int i = 0; i < NI; i++) begin
			next_filt[i] = (syncB[i] == syncC[i]) ? syncC[i] : filt[i];
		end
	end

	assign rise = filt & ~filtPrev;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			syncA <= '0;
			syncB <= '0;
			syncC <= '0;
			filt <= '0;
			filtPrev <= '0;
		end else if (clkEnable) begin
			syncA <= rawIn;
			syncB <= syncA;
			syncC <= syncB;
			filt <= next_filt;
			filtPrev <= filt;
		end
	end

	//----------------------------------------------------------------
	// persistence timers
	//----------------------------------------------------------------
	logic sinkMask;
	logic sinkDone;
	logic lvOvpOffDone;
	logic suOvpOffDone;
	logic notOff;

	assign notOff = (deviceState != regulator_fault_pkg::ST_OFF);

	persistence_timer #(.LIMIT(SINK_CYCLES)) sinkTimer (
		.core_clk(core_clk),
		.rst(rst),
		.clkEnable(clkEnable),
		.run(filt[regulator_fault_pkg::IN_SU_SINK] && !sinkMask && stepUpOn),
		.done(sinkDone)
	);

	persistence_timer #(.LIMIT(LV_OVP_OFF_CYCLES)) lvOvpTimer (
		.core_clk(core_clk),
		.rst(rst),
		.clkEnable(clkEnable),
		.run(statusFlags[regulator_fault_pkg::FL_LV_OVP] && filt[regulator_fault_pkg::IN_LV_OVP]
			&& !lvBuckOn && notOff),
		.done(lvOvpOffDone)
	);

	persistence_timer #(.LIMIT(SU_OVP_OFF_CYCLES)) suOvpTimer (
		.core_clk(core_clk),
		.rst(rst),
		.clkEnable(clkEnable),
		.run(statusFlags[regulator_fault_pkg::FL_SU_OVP] && filt[regulator_fault_pkg::IN_SU_OVP]
			&& !stepUpOn && notOff),
		.done(suOvpOffDone)
	);

	// any drop of the converter, wake or OFF restarts the ramp
	persistence_timer #(.LIMIT(SOFT_START_CYCLES)) softStartTimer (
		.core_clk(core_clk),
		.rst(rst),
		.clkEnable(clkEnable),
		.run(filt[regulator_fault_pkg::IN_RAMP_DONE] && filt[regulator_fault_pkg::IN_WAKE]
			&& stepUpOn && notOff),
		.done(stepUpSoftStartDone)
	);

	//----------------------------------------------------------------
	// fault reaction
	//----------------------------------------------------------------
	logic [regulator_fault_pkg::NUM_FLAGS-1:0] next_flags;
	logic [3:0] next_state;
	logic [ERR_CNT_WIDTH-1:0] next_errCnt;
	logic next_lvEn;
	logic next_suEn;
	logic next_lvOn;
	logic next_suOn;
	logic next_lock;
	logic next_pin;
	logic lvHold;
	logic suHold;
	logic next_lvHold;
	logic next_suHold;
	logic lvUvArm;
	logic suUvArm;
	logic next_lvUvArm;
	logic next_suUvArm;
	logic lvWarnIrq;
	logic suWarnIrq;
	logic next_lvWarnIrq;
	logic next_suWarnIrq;
	logic suShortPend;
	logic next_suShortPend;
	logic suSinkOff;
	logic next_suSinkOff;
	logic next_sinkMask;
	logic next_lvOvpLatched;
	logic next_suOvpLatched;
	logic errInc;
	logic lockOpen;
	logic lvFault;
	logic suFault;

	always_comb begin
		next_flags = statusFlags & ~swFlagClear;
		next_lvWarnIrq = lvWarnIrq & ~swFlagClear[regulator_fault_pkg::FL_LV_WARN];
		next_suWarnIrq = suWarnIrq & ~swFlagClear[regulator_fault_pkg::FL_SU_WARN];
		next_state = deviceState;
		next_lvEn = lvBuckEnableBit;
		next_suEn = stepUpEnableBit;
		next_lock = controlLock && !swControlLockClear;
		next_lvHold = lvHold && !filt[regulator_fault_pkg::IN_LV_COOL];
		next_suHold = suHold && !filt[regulator_fault_pkg::IN_SU_COOL];
		next_lvUvArm = lvUvArm;
		next_suUvArm = suUvArm;
		next_suShortPend = suShortPend;
		next_suSinkOff = suSinkOff;
		next_sinkMask = sinkMask && filt[regulator_fault_pkg::IN_SU_UV];
		next_lvOvpLatched = lvBuckOvpLatched;
		next_suOvpLatched = stepUpOvpLatched;
		errInc = 1'b0;
		lvFault = rise[regulator_fault_pkg::IN_LV_STD] || rise[regulator_fault_pkg::IN_LV_OVP];
		suFault = 1'b0;

		// software writes; a clear of the lock in the same command opens it
		lockOpen = !controlLock || swControlLockClear;
		if (swLvBuckEnableClear) begin
			next_lvEn = 1'b0;
		end else if (swLvBuckEnableSet && lockOpen) begin
			next_lvEn = 1'b1;
		end
		if (swStepUpEnableClear) begin
			next_suEn = 1'b0;
		end else if (swStepUpEnableSet && lockOpen) begin
			if (filt[regulator_fault_pkg::IN_SU_OVERLOAD] || filt[regulator_fault_pkg::IN_SU_SHORT]) begin
				next_suEn = 1'b0;
				errInc = 1'b1;
			end else begin
				next_suEn = 1'b1;
			end
		end

		// low-voltage buck
		if (rise[regulator_fault_pkg::IN_LV_WARN]) begin
			next_flags[regulator_fault_pkg::FL_LV_WARN] = 1'b1;
			if (lvBuckOvertempWarningIrqEnable) begin
				next_lvWarnIrq = 1'b1;
			end
		end
		if (rise[regulator_fault_pkg::IN_LV_STD]) begin
			next_flags[regulator_fault_pkg::FL_LV_STD] = 1'b1;
			next_lvHold = 1'b1;
		end
		if (rise[regulator_fault_pkg::IN_LV_OVP]) begin
			next_flags[regulator_fault_pkg::FL_LV_OVP] = 1'b1;
		end
		if (lvFault) begin
			next_lvEn = 1'b0;
			next_lvUvArm = 1'b1;
			errInc = 1'b1;
		end

		// step-up converter
		if (rise[regulator_fault_pkg::IN_SU_UV]) begin
			next_flags[regulator_fault_pkg::FL_SU_UV] = 1'b1;
		end
		if (rise[regulator_fault_pkg::IN_SU_OV]) begin
			next_flags[regulator_fault_pkg::FL_SU_OV] = 1'b1;
		end
		if (rise[regulator_fault_pkg::IN_SU_OVP]) begin
			next_flags[regulator_fault_pkg::FL_SU_OVP] = 1'b1;
			suFault = 1'b1;
		end
		if (rise[regulator_fault_pkg::IN_SU_OVERLOAD]) begin
			next_flags[regulator_fault_pkg::FL_SU_OVERLOAD] = 1'b1;
		end
		if (filt[regulator_fault_pkg::IN_SU_SINK] && !sinkMask && stepUpOn) begin
			next_flags[regulator_fault_pkg::FL_SU_SINK] = 1'b1;
		end
		if (sinkDone) begin
			next_suSinkOff = 1'b1;
			next_suShortPend = 1'b1;
		end
		if (rise[regulator_fault_pkg::IN_SU_SHORT]) begin
			next_suShortPend = 1'b1;
		end
		// the switch stays on to discharge the coil until below overload
		if (suShortPend && !filt[regulator_fault_pkg::IN_SU_OVERLOAD]) begin
			next_suShortPend = 1'b0;
			next_flags[regulator_fault_pkg::FL_SU_SHORT] = 1'b1;
			suFault = 1'b1;
		end
		if (rise[regulator_fault_pkg::IN_SU_WARN]) begin
			next_flags[regulator_fault_pkg::FL_SU_WARN] = 1'b1;
			if (stepUpOvertempWarningIrqEnable && driverEnableIrqN) begin
				next_suWarnIrq = 1'b1;
			end
		end
		if (rise[regulator_fault_pkg::IN_SU_STD]) begin
			next_flags[regulator_fault_pkg::FL_SU_STD] = 1'b1;
			next_suHold = 1'b1;
			suFault = 1'b1;
		end
		if (suFault) begin
			next_suEn = 1'b0;
			next_suSinkOff = 1'b0;
			next_suUvArm = 1'b1;
			errInc = 1'b1;
		end
		if (lvFault || suFault) begin
			next_lock = 1'b1;
		end

		// device state
		case (deviceState)
			regulator_fault_pkg::ST_ACTIVE: begin
				if (lvFault || suFault) begin
					next_state = regulator_fault_pkg::ST_SAFE;
				end
			end
			regulator_fault_pkg::ST_SAFE: begin
				if ((lvUvArm && filt[regulator_fault_pkg::IN_LV_UV] && lvBuckUndervoltageResetEnable)
					|| (suUvArm && filt[regulator_fault_pkg::IN_SU_UV]
					&& stepUpUndervoltageResetEnable)) begin
					next_state = regulator_fault_pkg::ST_RESET;
					next_lvUvArm = 1'b0;
					next_suUvArm = 1'b0;
					next_lvEn = regulator_fault_pkg::ENABLE_RESET;
					next_suEn = regulator_fault_pkg::ENABLE_RESET;
				end
			end
			regulator_fault_pkg::ST_RESET: begin
				if (lvFault || suFault) begin
					next_state = regulator_fault_pkg::ST_SAFE;
				end else if (!filt[regulator_fault_pkg::IN_LV_UV] && !filt[regulator_fault_pkg::IN_SU_UV]) begin
					next_state = regulator_fault_pkg::ST_ACTIVE;
				end
			end
			regulator_fault_pkg::ST_OFF: begin
				next_state = regulator_fault_pkg::ST_OFF;
			end
			default: begin
				next_state = regulator_fault_pkg::ST_OFF;
			end
		endcase
		if (lvOvpOffDone) begin
			next_state = regulator_fault_pkg::ST_OFF;
			next_lvOvpLatched = 1'b1;
		end
		if (suOvpOffDone) begin
			next_state = regulator_fault_pkg::ST_OFF;
			next_suOvpLatched = 1'b1;
		end

		// the enable bit may stay set while the hold keeps the rail down
		next_lvOn = next_lvEn && !next_lvHold && (next_state != regulator_fault_pkg::ST_OFF);
		next_suOn = next_suEn && !next_suHold && !next_suSinkOff
			&& (next_state != regulator_fault_pkg::ST_OFF);
		if (next_suOn && !stepUpOn) begin
			next_sinkMask = 1'b1;
		end

		// saturates so a fault storm cannot wrap back to a low count
		next_errCnt = deviceErrorCounter;
		if (errInc && (deviceErrorCounter != {ERR_CNT_WIDTH{1'b1}})) begin
			next_errCnt = deviceErrorCounter + 1'b1;
		end

		next_pin = !(|(next_flags & regulator_fault_pkg::FAULT_IRQ_MASK)
			|| next_lvWarnIrq || next_suWarnIrq);
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			statusFlags <= regulator_fault_pkg::FLAGS_RESET;
			deviceState <= regulator_fault_pkg::ST_ACTIVE;
			deviceErrorCounter <= '0;
			lvBuckEnableBit <= regulator_fault_pkg::ENABLE_RESET;
			stepUpEnableBit <= regulator_fault_pkg::ENABLE_RESET;
			lvBuckOn <= 1'b0;
			stepUpOn <= 1'b0;
			controlLock <= 1'b0;
			driverEnableIrqN <= 1'b1;
			lvHold <= 1'b0;
			suHold <= 1'b0;
			lvUvArm <= 1'b0;
			suUvArm <= 1'b0;
			lvWarnIrq <= 1'b0;
			suWarnIrq <= 1'b0;
			suShortPend <= 1'b0;
			suSinkOff <= 1'b0;
			sinkMask <= 1'b0;
			lvBuckOvpLatched <= 1'b0;
			stepUpOvpLatched <= 1'b0;
		end else if (clkEnable) begin
			statusFlags <= next_flags;
			deviceState <= next_state;
			deviceErrorCounter <= next_errCnt;
			lvBuckEnableBit <= next_lvEn;
			stepUpEnableBit <= next_suEn;
			lvBuckOn <= next_lvOn;
			stepUpOn <= next_suOn;
			controlLock <= next_lock;
			driverEnableIrqN <= next_pin;
			lvHold <= next_lvHold;
			suHold <= next_suHold;
			lvUvArm <= next_lvUvArm;
			suUvArm <= next_suUvArm;
			lvWarnIrq <= next_lvWarnIrq;
			suWarnIrq <= next_suWarnIrq;
			suShortPend <= next_suShortPend;
			suSinkOff <= next_suSinkOff;
			sinkMask <= next_sinkMask;
			lvBuckOvpLatched <= next_lvOvpLatched;
			stepUpOvpLatched <= next_suOvpLatched;
		end
	end
endmodule

/* regulator_fault_response_sva.sv */
// port-level checks on the regulator fault response
`timescale 1ns/1ps
module regulator_fault_response_sva #(
	parameter int ERR_CNT_WIDTH = 4
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic lvBuckCooled,
	input wire logic lvBuckOvertempWarningIrqEnable,
	input wire logic driverEnableIrqN,
	input wire logic lvBuckEnableBit,
	input wire logic lvBuckOn,
	input wire logic stepUpEnableBit,
	input wire logic stepUpOn,
	input wire logic [3:0] deviceState,
	input wire logic [ERR_CNT_WIDTH-1:0] deviceErrorCounter,
	input wire logic [regulator_fault_pkg::NUM_FLAGS-1:0] statusFlags,
	input wire logic lvBuckOvpLatched,
	input wire logic stepUpOvpLatched
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	a_lv_thermal_off: assert property (
		$rose(statusFlags[1]) |-> !lvBuckEnableBit && !lvBuckOn && deviceState == 4'h2
		&& !driverEnableIrqN) else $error("lv thermal shutdown reaction wrong");
	a_lv_ovp_off: assert property (
		$rose(statusFlags[2]) |-> !lvBuckEnableBit && !lvBuckOn && deviceState == 4'h2
		&& !driverEnableIrqN) else $error("lv overvoltage reaction wrong");
	a_su_short_off: assert property (
		$rose(statusFlags[7]) |-> !stepUpEnableBit && !stepUpOn && deviceState == 4'h2
		&& !driverEnableIrqN) else $error("step-up short reaction wrong");
	a_su_thermal_off: assert property (
		$rose(statusFlags[10]) |-> !stepUpEnableBit && !stepUpOn && deviceState == 4'h2
		&& !driverEnableIrqN) else $error("step-up thermal shutdown reaction wrong");
	a_su_ovp_off: assert property (
		$rose(statusFlags[5]) |-> !stepUpEnableBit && !stepUpOn && deviceState == 4'h2
		&& !driverEnableIrqN) else $error("step-up overvoltage reaction wrong");
	a_fault_count_step: assert property (
		|(statusFlags & ~$past(statusFlags) & 11'h4A6) |-> $past(deviceErrorCounter) == '1
		|| deviceErrorCounter == $past(deviceErrorCounter) + 1'b1)
		else $error("error counter did not step on fault");
	a_overload_keeps_on: assert property (
		$rose(statusFlags[6]) && stepUpOn |=> stepUpOn[*4])
		else $error("overload stopped the converter");
	a_warn_irq_low: assert property (
		$rose(statusFlags[0]) && lvBuckOvertempWarningIrqEnable |-> !driverEnableIrqN)
		else $error("warning interrupt missing");
	a_hot_hold_off: assert property (
		(!lvBuckCooled)[*6] ##0 (lvBuckEnableBit && !lvBuckOn) |=> !lvBuckOn)
		else $error("lv buck restarted while hot");
	a_lv_latch_off: assert property (
		$rose(lvBuckOvpLatched) |-> deviceState == 4'h8 && statusFlags[2] && !lvBuckOn)
		else $error("lv latch without off state");
	a_su_latch_off: assert property (
		$rose(stepUpOvpLatched) |-> deviceState == 4'h8 && statusFlags[5] && !stepUpOn)
		else $error("step-up latch without off state");
endmodule

bind regulator_fault_response regulator_fault_response_sva #(
	.ERR_CNT_WIDTH(ERR_CNT_WIDTH)
) u_regulator_fault_response_sva (
	.core_clk(core_clk), .rst(rst), .lvBuckCooled(lvBuckCooled),
	.lvBuckOvertempWarningIrqEnable(lvBuckOvertempWarningIrqEnable),
	.driverEnableIrqN(driverEnableIrqN), .lvBuckEnableBit(lvBuckEnableBit),
	.lvBuckOn(lvBuckOn), .stepUpEnableBit(stepUpEnableBit), .stepUpOn(stepUpOn),
	.deviceState(deviceState), .deviceErrorCounter(deviceErrorCounter),
	.statusFlags(statusFlags), .lvBuckOvpLatched(lvBuckOvpLatched),
	.stepUpOvpLatched(stepUpOvpLatched)
);

/* tb_regulator_fault_response.sv */
// self-checking bench for the regulator fault response
`timescale 1ns/1ps
module tb_regulator_fault_response;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [15:0] cmp = 16'hE004;
	logic [10:0] flagClr = 11'h000;
	logic [3:0] cfg = 4'h3;
	logic [2:0] req = 3'h0;
	logic clkEn = 1'b1;
	logic lvClr = 1'b0;
	logic lockClr, lvSet, suSet, suClr, irqN, lvEn, lvOn, suEn, suOn, ssDone, lock, lvLat, suLat;
	logic [3:0] st, errCnt, cnt;
	logic [10:0] flags;
	int errTotal = 0;
	int samplesChecked = 0;
	int cycles = 0;
	int stIn[3] = '{5, 6, 8};
	int stFl[3] = '{3, 4, 6};

	regulator_fault_response #(
		.SOFT_START_CYCLES(20), .SINK_CYCLES(10), .LV_OVP_OFF_CYCLES(8), .SU_OVP_OFF_CYCLES(8)
	) u_regulator_fault_response (
		.core_clk(core_clk), .rst(rst), .clkEnable(clkEn), .lvBuckOtWarn(cmp[0]),
		.lvBuckOtShutdown(cmp[1]), .lvBuckCooled(cmp[2]), .lvBuckOvp(cmp[3]),
		.lvBuckUv(cmp[4]), .stepUpUv(cmp[5]), .stepUpOv(cmp[6]), .stepUpOvp(cmp[7]),
		.stepUpOverload(cmp[8]), .stepUpShortCircuit(cmp[9]), .stepUpSink(cmp[10]),
		.stepUpOtWarn(cmp[11]), .stepUpOtShutdown(cmp[12]), .stepUpCooled(cmp[13]),
		.wideBuckRampDone(cmp[14]), .wakePin(cmp[15]), .swLvBuckEnableSet(lvSet),
		.swLvBuckEnableClear(lvClr), .swStepUpEnableSet(suSet), .swStepUpEnableClear(suClr),
		.swControlLockClear(lockClr), .swFlagClear(flagClr),
		.lvBuckOvertempWarningIrqEnable(cfg[3]), .stepUpOvertempWarningIrqEnable(cfg[2]),
		.lvBuckUndervoltageResetEnable(cfg[1]), .stepUpUndervoltageResetEnable(cfg[0]),
		.driverEnableIrqN(irqN), .lvBuckEnableBit(lvEn), .lvBuckOn(lvOn),
		.stepUpEnableBit(suEn), .stepUpOn(suOn), .stepUpSoftStartDone(ssDone),
		.controlLock(lock), .deviceState(st), .deviceErrorCounter(errCnt),
		.statusFlags(flags), .lvBuckOvpLatched(lvLat), .stepUpOvpLatched(suLat)
	);
	mcu_partner_model u_mcu_partner_model (
		.core_clk(core_clk), .driverEnableIrqN(irqN), .req(req), .lockClr(lockClr),
		.lvSet(lvSet), .suSet(suSet), .suClr(suClr)
	);

	initial begin
		forever #5 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 5000) begin
			errTotal++;
			tallyAndFinish;
		end
	end

	//--------------------------------
	// access tasks
	//--------------------------------
	task automatic settle(input int n);
		repeat (n) @(posedge core_clk);
		@(negedge core_clk);
	endtask
	task automatic setIn(input int i, input logic v);
		@(posedge core_clk);
		cmp[i] <= v;
	endtask
	task automatic clrFlags(input logic [10:0] m);
		@(posedge core_clk);
		flagClr <= m;
		@(posedge core_clk);
		flagClr <= 11'h000;
	endtask
	task automatic ask(input int i);
		@(posedge core_clk);
		req[i] <= 1'b1;
		@(posedge core_clk);
		req[i] <= 1'b0;
		settle(3);
	endtask
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		samplesChecked++;
		if (g !== e) begin
			errTotal++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// fault pulse short enough that the off-delay timer never expires
	task automatic fault(input int i, input int f, input logic su);
		logic [3:0] c0;
		c0 = errCnt;
		setIn(i, 1'b1);
		settle(6);
		setIn(i, 1'b0);
		settle(6);
		chk(flags[f], 1'b1);
		chk(su ? {suEn, suOn} : {lvEn, lvOn}, 2'h0);
		chk({st, irqN, errCnt}, {5'h04, c0 + 4'h1});
	endtask
	task automatic tallyAndFinish;
		if (errTotal == 0 && samplesChecked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	initial begin
		repeat (15) @(posedge core_clk);
		@(negedge core_clk);
		chk({lvEn, suEn, lvOn, suOn, lock, irqN, st}, 10'h311);
		@(posedge core_clk);
		rst <= 1'b0;
		settle(25);
		chk({suOn, ssDone}, 2'h3);
		setIn(15, 1'b0);
		settle(8);
		chk(ssDone, 1'b0);
		setIn(15, 1'b1);
		settle(12);
		chk(ssDone, 1'b0);
		settle(15);
		chk(ssDone, 1'b1);
		// a comparator change while frozen must wait, not vanish
		@(posedge core_clk);
		clkEn <= 1'b0;
		cmp[6] <= 1'b1;
		settle(8);
		chk(flags, 11'h000);
		@(posedge core_clk);
		clkEn <= 1'b1;
		settle(8);
		chk(flags, 11'h010);
		setIn(6, 1'b0);
		for (int k = 0; k < 4; k++) begin
			@(posedge core_clk);
			cfg[3:2] <= {2{k[0]}};
			cmp[k[1] ? 11 : 0] <= 1'b1;
			settle(8);
			chk({flags[k[1] ? 9 : 0], irqN}, {1'b1, !k[0]});
			setIn(k[1] ? 11 : 0, 1'b0);
			settle(6);
			clrFlags(11'h7FF);
			settle(2);
			chk(irqN, 1'b1);
		end
		foreach (stIn[j]) begin
			setIn(stIn[j], 1'b1);
			settle(8);
			chk(flags, 11'h1 << stFl[j]);
			chk({suOn, st, irqN}, 6'h23);
			setIn(stIn[j], 1'b0);
			settle(6);
			clrFlags(11'h7FF);
		end
		setIn(2, 1'b0);
		fault(1, 1, 1'b0);
		setIn(4, 1'b1);
		settle(8);
		chk({st, lvEn, lvOn}, 6'h12);
		setIn(4, 1'b0);
		settle(8);
		chk({st, lvOn}, 5'h02);
		setIn(2, 1'b1);
		settle(8);
		chk(lvOn, 1'b1);
		clrFlags(11'h7FF);
		setIn(13, 1'b0);
		fault(12, 10, 1'b1);
		ask(1);
		chk({suEn, suOn}, 2'h2);
		setIn(13, 1'b1);
		settle(8);
		chk(suOn, 1'b1);
		clrFlags(11'h7FF);
		fault(3, 2, 1'b0);
		ask(0);
		chk({lvEn, lvOn, lock}, 3'h6);
		@(posedge core_clk);
		lvClr <= 1'b1;
		@(posedge core_clk);
		lvClr <= 1'b0;
		settle(1);
		chk({lvEn, lvOn}, 2'h0);
		clrFlags(11'h7FF);
		fault(7, 5, 1'b1);
		setIn(5, 1'b1);
		settle(8);
		chk({st, suEn}, 5'h09);
		setIn(5, 1'b0);
		settle(8);
		clrFlags(11'h7FF);
		fault(9, 7, 1'b1);
		setIn(8, 1'b1);
		settle(6);
		cnt = errCnt;
		ask(1);
		chk({suEn, errCnt}, {1'b0, cnt + 4'h1});
		setIn(8, 1'b0);
		settle(6);
		ask(1);
		chk(suEn, 1'b1);
		@(posedge core_clk);
		cfg[0] <= 1'b0;
		cmp[5] <= 1'b1;
		ask(2);
		chk(suEn, 1'b0);
		ask(1);
		chk(suOn, 1'b1);
		clrFlags(11'h080);
		setIn(10, 1'b1);
		settle(8);
		chk(flags[8], 1'b0);
		setIn(5, 1'b0);
		settle(30);
		chk({flags[8:7], suEn, suOn}, 4'hC);
		setIn(10, 1'b0);
		clrFlags(11'h7FF);
		for (int r = 0; r < 2; r++) begin
			setIn(r ? 7 : 3, 1'b1);
			settle(25);
			chk({st, r ? suLat : lvLat}, 5'h11);
			@(posedge core_clk);
			rst <= 1'b1;
			cmp[r ? 7 : 3] <= 1'b0;
			repeat (2) @(posedge core_clk);
			rst <= 1'b0;
			settle(3);
			chk({st, lvLat, suLat}, 6'h04);
		end
		tallyAndFinish;
	end
endmodule
